// [shared/dps_pkg.sv]
package dps_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NPROF = 6;
  localparam int PRIO_W = 5;
  localparam int SRC_W = 5;
  localparam int PIDX_W = 3;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int RIDX_W = 14;
  localparam int OFF_W = 5;

  // ----------------------------------------------------------------
  // Register map (register indices; byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [RIDX_W-1:0] PROF_BASE_IDX = 14'h1600;
  localparam logic [RIDX_W-1:0] PROF_STRIDE = 14'h0020;
  localparam logic [OFF_W-1:0] OFF_PRIO_EN = 5'h00;
  localparam logic [OFF_W-1:0] OFF_SRC = 5'h01;
  localparam logic [RIDX_W-1:0] STATUS_IDX = 14'h16c0;
  localparam logic [RIDX_W-1:0] CTRL_IDX = 14'h16c1;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int EN_BIT = 0;
  localparam int PRIO_LSB = 1;
  localparam int PRIO_MSB = 5;
  localparam int SRC_MSB = 4;
  localparam int RUN_BIT = 0;
  localparam int STAT_LOCK_BIT = 3;

  // ----------------------------------------------------------------
  // Reset values and thresholds
  // ----------------------------------------------------------------
  localparam logic [PRIO_W-1:0] PRIO_RST = 5'h00;
  localparam logic EN_RST = 1'b0;
  localparam logic [SRC_W-1:0] SRC_RST = 5'h00;
  localparam logic RUN_RST = 1'b1;
  localparam logic [PRIO_W-1:0] REVERT_GAP = 5'h07;
  localparam logic [PIDX_W-1:0] PIDX_RST = 3'h0;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

  typedef enum {DPS_ST_IDLE, DPS_ST_LOCKED} dps_state_e;

  // Index of a profile register from profile number and sub-offset
  function automatic logic [RIDX_W-1:0] dps_prof_idx(input logic [PIDX_W-1:0] p,
                                                     input logic [OFF_W-1:0] off);
    logic [RIDX_W-1:0] step;
    // Stride product fits the index width; profile number is at most five
    step = RIDX_W'(PROF_STRIDE * RIDX_W'(p));
    return RIDX_W'(PROF_BASE_IDX + step + RIDX_W'(off));
  endfunction

endpackage

// [shared/dps_sel_if.sv]
`timescale 1ns/1ps
// Candidate set and the best pick returned by the priority picker
interface dps_sel_if;
  import dps_pkg::*;
  logic [NPROF-1:0] cand;
  logic [NPROF-1:0][PRIO_W-1:0] prio;
  logic found;
  logic [PIDX_W-1:0] best_idx;
  logic [PRIO_W-1:0] best_prio;

  modport owner (output cand, output prio, input found, input best_idx, input best_prio);
  modport picker (input cand, input prio, output found, output best_idx, output best_prio);
endinterface

// [rtl/dps_prio_pick.sv]
`timescale 1ns/1ps
module dps_prio_pick
  import dps_pkg::*;
(
  dps_sel_if.picker sel
);

  // ----------------------------------------------------------------
  // Smallest code wins; strict compare keeps the lower profile on ties
  // ----------------------------------------------------------------
  // smaller code outranks
  always_comb begin
    sel.found = 1'b0;
    sel.best_idx = PIDX_RST;
    sel.best_prio = PRIO_RST;
    for (int i = 0; i < NPROF; i++) begin
      if (sel.cand[i] && (!sel.found || (sel.prio[i] < sel.best_prio))) begin
        sel.found = 1'b1;
        sel.best_idx = PIDX_W'(i);
        sel.best_prio = sel.prio[i];
      end
    end
  end

endmodule

// [rtl/dps_switch_top.sv]
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
// Functional notes
// - Profiles 1.1-1.5 copy profile 1.0 layout, each 0x20 higher, same defaults.
// - Each profile has a read/write 5-bit priority at bits 5:1, reset zero.
// - Priority code zero is most preferred, 0x1F least; smaller wins the pick from idle, an active profile yields only past a gap of seven.
// - Every profile holds its own independently programmed priority.
// - Switch to valid inactive better profile when priority gap exceeds seven.
// - Stay on active profile when better candidate is zero to seven levels ahead.
// - Profile is used only while its enable bit 0 is set.
// - Each profile carries a 5-bit source selection field.
module dps_switch_top
  import dps_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [NPROF-1:0] prof_valid,
  output logic loop_active,
  output logic [PIDX_W-1:0] active_profile,
  output logic [SRC_W-1:0] active_source
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [NPROF-1:0][PRIO_W-1:0] prio_ff;
  logic [NPROF-1:0] en_ff;
  logic [NPROF-1:0][SRC_W-1:0] src_ff;
  logic run_ff;
  logic wait_ff;
  logic [DATA_W-1:0] rdata_ff;
  dps_state_e state_ff;
  dps_state_e nxt_state;
  logic [PIDX_W-1:0] act_idx_ff;
  logic [PIDX_W-1:0] nxt_act_idx;
  logic lock_ff;
  logic [SRC_W-1:0] src_out_ff;
  logic [RIDX_W-1:0] reg_idx;
  logic word_ok;
  logic wr_go;
  logic lane0;
  logic [DATA_W-1:0] nxt_rdata;
  logic act_ok;
  logic [PRIO_W-1:0] act_prio;
  logic [PRIO_W-1:0] gap;

  dps_sel_if sel ();

  dps_prio_pick u_pick (
    .sel(sel.picker)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Registers sit one per aligned word; byte lane 0 carries the 8-bit data
  assign reg_idx = avs_address[ADDR_W-1:2];
  assign word_ok = (avs_address[1:0] == 2'h0);
  assign lane0 = avs_byteenable[0];
  // Write lands on the edge where the master sees waitrequest low
  assign wr_go = avs_write && !wait_ff && word_ok && lane0;

  // ----------------------------------------------------------------
  // Waitrequest: one wait cycle, then a single ready cycle
  // ----------------------------------------------------------------
  // Held high while idle so a new request always waits one edge for data
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wait_ff <= 1'b1;
    end else if ((avs_read || avs_write) && wait_ff) begin
      wait_ff <= 1'b0;
    end else begin
      wait_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Per-profile registers
  // ----------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < NPROF; gp++) begin : g_prof
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          prio_ff[gp] <= PRIO_RST;
          en_ff[gp] <= EN_RST;
        end else if (wr_go && reg_idx == dps_prof_idx(PIDX_W'(gp), OFF_PRIO_EN)) begin
          prio_ff[gp] <= avs_writedata[PRIO_MSB:PRIO_LSB];
          en_ff[gp] <= avs_writedata[EN_BIT];
        end
      end

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          src_ff[gp] <= SRC_RST;
        end else if (wr_go && reg_idx == dps_prof_idx(PIDX_W'(gp), OFF_SRC)) begin
          src_ff[gp] <= avs_writedata[SRC_MSB:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Clearing run drops the active profile and freezes selection
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_ff <= RUN_RST;
    end else if (wr_go && reg_idx == CTRL_IDX) begin
      run_ff <= avs_writedata[RUN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped words and misaligned addresses read zero; reserved bits zero
  always_comb begin
    nxt_rdata = RDATA_ZERO;
    if (word_ok) begin
      for (int i = 0; i < NPROF; i++) begin
        if (reg_idx == dps_prof_idx(PIDX_W'(i), OFF_PRIO_EN)) begin
          nxt_rdata[PRIO_MSB:PRIO_LSB] = prio_ff[i];
          nxt_rdata[EN_BIT] = en_ff[i];
        end
        if (reg_idx == dps_prof_idx(PIDX_W'(i), OFF_SRC)) begin
          nxt_rdata[SRC_MSB:0] = src_ff[i];
        end
      end
      if (reg_idx == CTRL_IDX) begin
        nxt_rdata[RUN_BIT] = run_ff;
      end
      if (reg_idx == STATUS_IDX) begin
        nxt_rdata[PIDX_W-1:0] = act_idx_ff;
        nxt_rdata[STAT_LOCK_BIT] = lock_ff;
      end
    end
  end

  // Data captured on the edge that drops waitrequest, so it stands with it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_ff <= RDATA_ZERO;
    end else if (avs_read && wait_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Candidate set for the picker
  // ----------------------------------------------------------------
  // disabled excluded
  always_comb begin
    for (int i = 0; i < NPROF; i++) begin
      sel.cand[i] = en_ff[i] && prof_valid[i]
                    && !(state_ff == DPS_ST_LOCKED && act_idx_ff == PIDX_W'(i));
      sel.prio[i] = prio_ff[i];
    end
  end

  assign act_prio = prio_ff[act_idx_ff];
  assign act_ok = en_ff[act_idx_ff] && prof_valid[act_idx_ff];
  assign gap = act_prio - sel.best_prio;

  // ----------------------------------------------------------------
  // Selection state machine
  // ----------------------------------------------------------------
  // A lost or disabled active profile goes idle for one cycle, then the
  // best remaining one is taken; this costs a cycle but keeps one path
  always_comb begin
    nxt_state = state_ff;
    nxt_act_idx = act_idx_ff;
    unique case (state_ff)
      DPS_ST_IDLE: begin
        if (run_ff && sel.found) begin
          nxt_state = DPS_ST_LOCKED;
          nxt_act_idx = sel.best_idx;
        end
      end
      DPS_ST_LOCKED: begin
        if (!run_ff || !act_ok) begin
          nxt_state = DPS_ST_IDLE;
        end else if (sel.found && (sel.best_prio < act_prio) && (gap > REVERT_GAP)) begin
          nxt_act_idx = sel.best_idx;
        end
        // otherwise hold; spacing is software's job
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= DPS_ST_IDLE;
      act_idx_ff <= PIDX_RST;
    end else begin
      state_ff <= nxt_state;
      act_idx_ff <= nxt_act_idx;
    end
  end

  // Outputs track the next state so they line up with state_ff
  // route active source
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lock_ff <= 1'b0;
      src_out_ff <= SRC_RST;
    end else begin
      lock_ff <= (nxt_state == DPS_ST_LOCKED);
      src_out_ff <= (nxt_state == DPS_ST_LOCKED) ? src_ff[nxt_act_idx] : SRC_RST;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign loop_active = lock_ff;
  assign active_profile = act_idx_ff;
  assign active_source = src_out_ff;

endmodule

// [dv/dps_switch_properties.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker for the profile switch
// ----------------------------------------------------------------
module dps_switch_properties
  import dps_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [NPROF-1:0] prof_valid,
  input wire logic loop_active,
  input wire logic [PIDX_W-1:0] active_profile,
  input wire logic [SRC_W-1:0] active_source
);
  logic [NPROF-1:0] valid_q;
  // Validity one edge back, the cause seen by a new pick
  always_ff @(posedge ref_clk) begin
    valid_q <= prof_valid;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait");
  AST_ACK_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer longer than one cycle");
  AST_BYTE_WIDE: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data above the register byte");
  AST_IDLE_SRC: assert property (!loop_active |-> active_source == 5'h00)
    else $error("source shown while idle");
  AST_DROP_LOST: assert property (loop_active && !prof_valid[active_profile] |=> !loop_active)
    else $error("invalid profile kept active");
  AST_NONE_IDLE: assert property (prof_valid == '0 |=> !loop_active)
    else $error("active with no valid profile");
  AST_PICK_VALID: assert property ($rose(loop_active) |-> valid_q[active_profile])
    else $error("picked profile was not valid");
  AST_SWITCH_VALID: assert property (loop_active && $changed(active_profile) |-> valid_q[active_profile])
    else $error("switched to profile that was not valid");
  cover property ($rose(loop_active));
  cover property (loop_active && $changed(active_profile) && $past(loop_active));
  cover property (avs_read && !avs_waitrequest);
endmodule

bind dps_switch_top dps_switch_properties u_prop (.ref_clk, .rst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .prof_valid,
  .loop_active, .active_profile, .active_source);

// [dv/dps_switch_top_test.sv]
`timescale 1ns/1ps
module dps_switch_top_test
  import dps_pkg::*;
;
  logic ref_clk, rst, avs_read, avs_write, avs_waitrequest, loop_active;
  logic [ADDR_W-1:0] avs_address;
  logic [DATA_W-1:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic [NPROF-1:0] prof_valid;
  logic [PIDX_W-1:0] active_profile;
  logic [SRC_W-1:0] active_source;
  int err_total, samples_checked;
  logic [7:0] src_tab [NPROF] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08};

  dps_switch_top dut (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .prof_valid, .loop_active,
    .active_profile, .active_source);

  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request until waitrequest is seen low, bounded
  task automatic bus(input logic rd, input logic [13:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= {idx, 2'b00};
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  function automatic logic [13:0] pidx(input int p, input int off);
    return PROF_BASE_IDX + PROF_STRIDE * 14'(p) + 14'(off);
  endfunction

  task automatic rd_chk(input logic [13:0] idx, input logic [7:0] exp);
    bus(1'b1, idx, 8'h00);
    chk("readdata", {24'h0, exp}, q);
  endtask

  task automatic setp(input int p, input logic en, input logic [4:0] pr);
    bus(1'b0, pidx(p, 0), {2'b00, pr, en});
    bus(1'b0, pidx(p, 1), src_tab[p]);
  endtask

  // Four edges cover the idle cycle taken when the active profile is lost
  task automatic sel_chk(input logic [5:0] v, input logic act, input int p);
    @(posedge ref_clk);
    prof_valid <= v;
    repeat (4) @(posedge ref_clk);
    chk("selection", {23'h0, act, 3'(p), act ? src_tab[p][4:0] : 5'h00},
        {23'h0, loop_active, act ? active_profile : 3'(p), active_source});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    for (int p = 0; p < NPROF; p++) begin
      rd_chk(pidx(p, 0), 8'h00);
      rd_chk(pidx(p, 1), 8'h00);
    end
    rd_chk(14'h1602, 8'h00);
    chk("loop_active", 32'h0, {31'h0, loop_active});
  endtask

  // Reserved bits written high must read back low
  task automatic t_regs;
    for (int p = 0; p < NPROF; p++) begin
      bus(1'b0, pidx(p, 0), {2'b11, 5'(p + 3), 1'b1});
      rd_chk(pidx(p, 0), {2'b00, 5'(p + 3), 1'b1});
      bus(1'b0, pidx(p, 1), 8'he0 | src_tab[p]);
      rd_chk(pidx(p, 1), src_tab[p]);
    end
    @(posedge ref_clk);
    avs_byteenable <= 4'he;
    bus(1'b0, pidx(0, 0), 8'h00);
    avs_byteenable <= 4'hf;
    rd_chk(pidx(0, 0), 8'h07);
    bus(1'b0, 14'h1602, 8'hff);
    rd_chk(14'h1602, 8'h00);
  endtask

  task automatic t_pick;
    sel_chk(6'b111110, 1'b1, 1);
    for (int p = 0; p < NPROF; p++) begin
      sel_chk(6'(1 << p), 1'b1, p);
    end
    sel_chk(6'b000000, 1'b0, 5);
    setp(2, 1'b1, 5'h00);
    setp(4, 1'b1, 5'h00);
    sel_chk(6'b010100, 1'b1, 2);
    setp(1, 1'b0, 5'h01);
    sel_chk(6'b000010, 1'b0, 2);
  endtask

  // Gap of seven stays, gap of eight switches
  task automatic t_revert;
    setp(0, 1'b1, 5'h14);
    setp(1, 1'b1, 5'h0d);
    setp(2, 1'b1, 5'h0c);
    sel_chk(6'b000001, 1'b1, 0);
    sel_chk(6'b000011, 1'b1, 0);
    sel_chk(6'b000111, 1'b1, 2);
    setp(2, 1'b0, 5'h0c);
    sel_chk(6'b000111, 1'b1, 1);
  endtask

  // Status shows the locked profile; clearing run forces idle, setting it picks again
  task automatic t_ctrl;
    rd_chk(STATUS_IDX, 8'h09);
    rd_chk(CTRL_IDX, 8'h01);
    bus(1'b0, CTRL_IDX, 8'h00);
    sel_chk(6'b000111, 1'b0, 1);
    rd_chk(STATUS_IDX, 8'h01);
    bus(1'b0, CTRL_IDX, 8'h01);
    sel_chk(6'b000111, 1'b1, 1);
    rd_chk(STATUS_IDX, 8'h09);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    results;
  end

  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
    prof_valid = '0;
    err_total = 0;
    samples_checked = 0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset;
    t_regs;
    t_pick;
    t_revert;
    t_ctrl;
    results;
  end
endmodule
